// ---- cam_decoder_sva.sv ----
// assertions on the decoder ports
`include "cam_defines.vh"
module cam_decoder_sva (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [15:0] DIN,
  input wire logic [15:0] DOUT,
  input wire logic [15:0] STATUS_IN,
  input wire logic MEM_WR,
  input wire logic [11:0] MEM_ADDR,
  input wire logic MEM_VAL_WR,
  input wire logic SEARCH_GO,
  input wire logic [2:0] SEARCH_VAL,
  input wire logic [63:0] SEARCH_MASK,
  input wire logic CHAIN_FULL_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_ff, ovr_ff, vbc_ff;
  logic [2:0] code_ff;
  wire cmd_w = CMD_WR && CLK_EN;
  wire cmd_r = CMD_RD && CLK_EN;
  wire plain = cmd_w && !pend_ff && !ovr_ff && DIN[15:12] == 4'h0;
  wire quiet = !(MEM_WR || MEM_VAL_WR || SEARCH_GO);
  // address cycles and override targets are not instructions
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pend_ff <= 1'b0;
      ovr_ff <= 1'b0;
      vbc_ff <= 1'b0;
      code_ff <= 3'h0;
    end else begin
      if (cmd_w) pend_ff <= plain && DIN[11];
      if (cmd_w || cmd_r) ovr_ff <= plain && DIN[11:8] == 4'h2;
      if (plain) code_ff <= DIN[5:3];
      if (plain) vbc_ff <= DIN[10:8] == 3'h4;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_flagged;
    plain && DIN[11];
  endsequence
  sequence s_vbc_addr;
    cmd_w && pend_ff && vbc_ff;
  endsequence
  a_defer_exec: assert property (s_flagged |=> quiet)
    else $error("flagged instruction ran before its address");
  a_addr_used: assert property (s_vbc_addr |=> MEM_VAL_WR && MEM_ADDR == $past(DIN[11:0]))
    else $error("validity write missed the supplied address");
  a_fill_drops: assert property (plain && DIN == 16'h0700 |=> !CHAIN_FULL_N)
    else $error("chain full output not driven low");
  a_full_holds: assert property (!CHAIN_FULL_N |=> !CHAIN_FULL_N)
    else $error("chain full output released without reset");
  a_status_read: assert property (cmd_r && !ovr_ff |=> DOUT == $past(STATUS_IN))
    else $error("plain command read did not return status");
  a_id_read: assert property (cmd_r && ovr_ff && code_ff == 3'h3 |=> DOUT[15:4] == `DEVICE_ID)
    else $error("device id missing from selector read");
  a_forced_search: assert property (plain && DIN[15:3] == 13'h00a0 |=>
    SEARCH_GO && SEARCH_VAL == $past(DIN[2:0]))
    else $error("forced search not started with its code");
  a_empty_mask: assert property (plain && DIN == {13'h00a0, `VAL_EMPTY} |=> SEARCH_MASK == '1)
    else $error("empty search left data bits unmasked");
  a_idle_quiet: assert property (plain && DIN == 16'h0300 |=> quiet)
    else $error("idle instruction caused activity");
endmodule
bind cam_instruction_decoder cam_decoder_sva cam_decoder_sva_i (.REF_CLK(REF_CLK), .SRST(SRST),
  .CLK_EN(CLK_EN), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .DIN(DIN), .DOUT(DOUT),
  .STATUS_IN(STATUS_IN), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_VAL_WR(MEM_VAL_WR),
  .SEARCH_GO(SEARCH_GO), .SEARCH_VAL(SEARCH_VAL), .SEARCH_MASK(SEARCH_MASK),
  .CHAIN_FULL_N(CHAIN_FULL_N));

// ---- cam_defines.vh ----
// shared constants for the cam instruction decoder
`ifndef CAM_DEFINES_VH
`define CAM_DEFINES_VH
// instruction groups, bits 10:8
`define GRP_READ_SRC 3'h0
`define GRP_WRITE_DST 3'h1
`define GRP_OVERRIDE 3'h2
`define GRP_TRANSFER 3'h3
`define GRP_VALIDITY 3'h4
`define GRP_SEARCH 3'h5
`define GRP_SPECIAL 3'h6
`define GRP_FILL 3'h7
// field positions
`define F_FLAG 11
`define F_GRP_HI 10
`define F_GRP_LO 8
`define F_MSK_HI 7
`define F_MSK_LO 6
`define F_DST_HI 5
`define F_DST_LO 3
`define F_SRC_HI 2
`define F_SRC_LO 0
`define F_TOP_HI 15
`define F_TOP_LO 12
// resource codes
`define RES_KEY 3'h0
`define RES_MASK1 3'h1
`define RES_MASK2 3'h2
`define RES_MEM_PTR 3'h4
`define RES_MEM_ABS 3'h4
`define RES_MEM_MATCH 3'h5
`define RES_MEM_FREE 3'h6
// override register codes
`define OVR_CONTROL 3'h0
`define OVR_PAGE 3'h1
`define OVR_SEGMENT 3'h2
`define OVR_READ_SEL 3'h3
`define OVR_WRITE_SEL 3'h4
`define OVR_NEXT_FREE 3'h5
`define OVR_ADDRESS 3'h6
`define OVR_DEV_SEL 3'h7
// mask select codes
`define MSK_NONE 2'h0
`define MSK_ONE 2'h1
`define MSK_TWO 2'h2
// special operations
`define SPC_FOREGROUND 3'h0
`define SPC_BACKGROUND 3'h1
`define SPC_REWIND 3'h2
`define SPC_SHIFT_RIGHT 3'h3
`define SPC_SHIFT_LEFT 3'h4
// search validity codes
`define VAL_VALID 3'h4
`define VAL_EMPTY 3'h5
// control register fields
`define CTL_DIR_BIT 0
`define CTL_INC_BIT 1
`define CTL_WID_HI 3
`define CTL_WID_LO 2
// misc widths and values
`define WORD_BITS 64
`define SEG_BITS 16
`define LAST_SEG 2'h3
`define CONTROL_RST 16'h0000
`define DEVICE_ID 12'h5a5
`define ZERO16 16'h0000
`define ZERO64 64'h0000000000000000
`endif

// ---- cam_instruction_decoder.v ----
// command-cycle instruction decoder for the 64-bit cam
`include "cam_defines.vh"
module cam_instruction_decoder (
  // clock, reset, enable
  input wire REF_CLK,
  input wire SRST,
  input wire CLK_EN,
  // command and data cycles
  input wire CMD_WR,
  input wire CMD_RD,
  input wire DATA_WR,
  input wire DATA_RD,
  input wire [15:0] DIN,
  output reg [15:0] DOUT,
  // status and match inputs
  input wire [15:0] STATUS_IN,
  input wire [11:0] MATCH_ADDR,
  input wire [11:0] FREE_ADDR,
  // memory array port
  output reg MEM_WR,
  output reg [11:0] MEM_ADDR,
  output reg [63:0] MEM_WDATA,
  output reg [63:0] MEM_BITEN,
  output reg MEM_VAL_WR,
  output reg [2:0] MEM_VAL,
  input wire [63:0] MEM_RDATA,
  // compare request
  output reg SEARCH_GO,
  output reg [2:0] SEARCH_VAL,
  output reg [63:0] SEARCH_MASK,
  // chain
  output reg CHAIN_FULL_N
);
  // persistent and banked state
  reg [63:0] key_ff, mask2_ff;
  reg [63:0] mask1_ff [0:1];
  reg [15:0] control_ff [0:1];
  reg [15:0] segment_ff [0:1];
  reg [11:0] addr_ff [0:1];
  reg [5:0] rsel_ff [0:1];
  reg [8:0] wsel_ff [0:1];
  reg [15:0] page_ff, devsel_ff;
  reg bank_ff;
  reg [1:0] wseg_ff, rseg_ff;
  reg ovr_ff;
  reg [2:0] ovr_reg_ff;
  reg pend_ff;
  reg [15:0] pend_op_ff;
  wire [15:0] ctl = control_ff[bank_ff];
  wire [11:0] aptr = addr_ff[bank_ff];
  wire [2:0] rsrc = rsel_ff[bank_ff][2:0];
  wire [2:0] wdst = wsel_ff[bank_ff][5:3];
  wire [1:0] wmsk = wsel_ff[bank_ff][7:6];
  wire [11:0] astep = ctl[`CTL_DIR_BIT] ? aptr - 12'h001 : aptr + 12'h001;
  wire [11:0] anext = ctl[`CTL_INC_BIT] ? astep : aptr;
  wire [63:0] key_sh, mask_sh;
  // decode the instruction about to run: either fresh or waiting on address
  wire take_addr = CMD_WR && pend_ff && !ovr_ff;
  wire fresh = CMD_WR && !pend_ff && !ovr_ff && DIN[`F_TOP_HI:`F_TOP_LO] == 4'h0;
  wire [15:0] op = take_addr ? pend_op_ff : DIN;
  wire defer = fresh && DIN[`F_FLAG];
  wire exec = (fresh && !defer) || take_addr;
  wire [2:0] grp = op[`F_GRP_HI:`F_GRP_LO];
  wire [2:0] fd = op[`F_DST_HI:`F_DST_LO];
  wire [2:0] fs = op[`F_SRC_HI:`F_SRC_LO];
  wire [1:0] fm = op[`F_MSK_HI:`F_MSK_LO];
  // shift unit follows the cam field width; direction comes from the running op
  cam_shifter cam_shifter_i (
    .key_in(key_ff),
    .mask_in(mask2_ff),
    .width_sel(ctl[`CTL_WID_HI:`CTL_WID_LO]),
    .left(fs == `SPC_SHIFT_LEFT),
    .key_out(key_sh),
    .mask_out(mask_sh)
  );
  wire [11:0] ex_addr = take_addr ? DIN[11:0] : aptr;
  // transfer source word
  reg [63:0] src_word;
  // limitation: the array word is the one at the address last presented
  always @* begin
    if (fs[2] && fd < `RES_MEM_PTR) begin
      // register target: source bit 2 names the array
      src_word = MEM_RDATA;
    end else begin
      case (fs[1:0])
        2'h0: src_word = key_ff;
        2'h1: src_word = mask1_ff[bank_ff];
        2'h2: src_word = mask2_ff;
        default: src_word = MEM_RDATA;
      endcase
    end
  end
  // mask selection shared by writes, transfers and searches
  function [63:0] pick_mask;
    input [1:0] sel;
    input [63:0] m1;
    input [63:0] m2;
    begin
      pick_mask = (sel == `MSK_ONE) ? m1 : (sel == `MSK_TWO) ? m2 : `ZERO64;
    end
  endfunction
  wire [63:0] wmask = pick_mask(wmsk, mask1_ff[bank_ff], mask2_ff);
  wire [63:0] tmask = pick_mask(fm, mask1_ff[bank_ff], mask2_ff);
  // segment lane for a 16-bit data write
  wire [63:0] lane = 64'h000000000000ffff << {wseg_ff, 4'h0};
  wire [63:0] wide = {4{DIN}};
  wire [3:0] trsrc = {fs[2], fs & 3'h3};
  integer b;
  always @(posedge REF_CLK) begin
    if (SRST) begin
      key_ff <= `ZERO64;
      mask2_ff <= `ZERO64;
      for (b = 0; b < 2; b = b + 1) begin
        mask1_ff[b] <= `ZERO64;
        control_ff[b] <= `CONTROL_RST;
        segment_ff[b] <= `ZERO16;
        addr_ff[b] <= 12'h000;
        rsel_ff[b] <= 6'h00;
        wsel_ff[b] <= 9'h000;
      end
      page_ff <= `ZERO16;
      devsel_ff <= `ZERO16;
      bank_ff <= 1'b0;
      wseg_ff <= 2'h0;
      rseg_ff <= 2'h0;
      ovr_ff <= 1'b0;
      ovr_reg_ff <= 3'h0;
      pend_ff <= 1'b0;
      pend_op_ff <= `ZERO16;
      DOUT <= `ZERO16;
      MEM_WR <= 1'b0;
      MEM_ADDR <= 12'h000;
      MEM_WDATA <= `ZERO64;
      MEM_BITEN <= `ZERO64;
      MEM_VAL_WR <= 1'b0;
      MEM_VAL <= 3'h0;
      SEARCH_GO <= 1'b0;
      SEARCH_VAL <= 3'h0;
      SEARCH_MASK <= `ZERO64;
      CHAIN_FULL_N <= 1'b1;
    end else if (CLK_EN) begin
      MEM_WR <= 1'b0;
      MEM_VAL_WR <= 1'b0;
      SEARCH_GO <= 1'b0;
      if (ovr_ff && CMD_WR) begin
        ovr_ff <= 1'b0;
        // selectors and next-free are read only
        case (ovr_reg_ff)
          `OVR_CONTROL: control_ff[bank_ff] <= DIN;
          `OVR_PAGE: page_ff <= DIN;
          `OVR_SEGMENT: segment_ff[bank_ff] <= DIN;
          `OVR_ADDRESS: addr_ff[bank_ff] <= DIN[11:0];
          `OVR_DEV_SEL: devsel_ff <= DIN;
          default: ovr_ff <= 1'b0;
        endcase
      end
      if (CMD_RD) begin
        ovr_ff <= 1'b0;
        if (!ovr_ff) begin
          DOUT <= STATUS_IN;
        end else begin
          case (ovr_reg_ff)
            `OVR_CONTROL: DOUT <= control_ff[bank_ff];
            `OVR_PAGE: DOUT <= page_ff;
            `OVR_SEGMENT: DOUT <= segment_ff[bank_ff];
            // id rides on the upper bits
            `OVR_READ_SEL: DOUT <= {`DEVICE_ID, 1'b0, rsrc};
            `OVR_WRITE_SEL: DOUT <= {7'h00, wsel_ff[bank_ff]};
            `OVR_NEXT_FREE: DOUT <= {4'h0, FREE_ADDR};
            `OVR_ADDRESS: DOUT <= {4'h0, aptr};
            default: DOUT <= devsel_ff;
          endcase
        end
      end
      // remember flagged op until its address
      if (defer) begin
        pend_ff <= 1'b1;
        pend_op_ff <= DIN;
      end
      if (take_addr) begin
        pend_ff <= 1'b0;
        addr_ff[bank_ff] <= DIN[11:0];
      end
      if (exec) begin
        case (grp)
          `GRP_READ_SRC: begin
            rsel_ff[bank_ff] <= {3'h0, fs};
            rseg_ff <= 2'h0;
            // array answers at MEM_ADDR, so present the first read address now
            MEM_ADDR <= fs == `RES_MEM_MATCH ? MATCH_ADDR : ex_addr;
          end
          `GRP_WRITE_DST: begin
            wsel_ff[bank_ff] <= op[8:0];
            wseg_ff <= 2'h0;
          end
          `GRP_OVERRIDE: begin
            ovr_ff <= 1'b1;
            ovr_reg_ff <= fd;
          end
          `GRP_TRANSFER: begin
            if ({1'b0, fd} != trsrc) begin
              case (fd)
                `RES_KEY: key_ff <= (key_ff & tmask) | (src_word & ~tmask);
                `RES_MASK1: mask1_ff[bank_ff] <= src_word;
                `RES_MASK2: mask2_ff <= src_word;
                default: begin
                  MEM_WR <= 1'b1;
                  MEM_ADDR <= fd == `RES_MEM_MATCH ? MATCH_ADDR : ex_addr;
                  MEM_WDATA <= src_word;
                  MEM_BITEN <= ~tmask;
                  MEM_VAL_WR <= fs[2];
                  MEM_VAL <= `VAL_VALID;
                end
              endcase
              if (fd == `RES_MEM_PTR || fs[2]) begin
                addr_ff[bank_ff] <= ctl[`CTL_INC_BIT] ?
                  (ctl[`CTL_DIR_BIT] ? ex_addr - 12'h001 : ex_addr + 12'h001) : ex_addr;
              end
            end
          end
          `GRP_VALIDITY: begin
            MEM_VAL_WR <= 1'b1;
            MEM_VAL <= fs;
            MEM_ADDR <= fd == `RES_MEM_MATCH ? MATCH_ADDR :
              fd == `RES_MEM_FREE ? FREE_ADDR : ex_addr;
            if (fd == `RES_MEM_PTR) begin
              addr_ff[bank_ff] <= ctl[`CTL_INC_BIT] ?
                (ctl[`CTL_DIR_BIT] ? ex_addr - 12'h001 : ex_addr + 12'h001) : ex_addr;
            end
          end
          `GRP_SEARCH: begin
            SEARCH_GO <= 1'b1;
            SEARCH_VAL <= fs;
            SEARCH_MASK <= fs == `VAL_EMPTY ? ~`ZERO64 : wmask;
          end
          `GRP_SPECIAL: begin
            case (fs)
              `SPC_FOREGROUND: bank_ff <= 1'b0;
              `SPC_BACKGROUND: bank_ff <= 1'b1;
              `SPC_REWIND: begin
                wseg_ff <= segment_ff[bank_ff][1:0];
                rseg_ff <= segment_ff[bank_ff][3:2];
              end
              default: begin
                if (fd == `RES_KEY) key_ff <= key_sh;
                if (fd == `RES_MASK2) mask2_ff <= mask_sh;
              end
            endcase
          end
          default: CHAIN_FULL_N <= 1'b0;
        endcase
      end
      // data write to the persistent target, 16 bits per segment
      if (DATA_WR) begin
        wseg_ff <= wseg_ff + 2'h1;
        case (wdst)
          `RES_KEY: key_ff <= (key_ff & (~lane | wmask)) | (wide & lane & ~wmask);
          `RES_MASK1: mask1_ff[bank_ff] <= (mask1_ff[bank_ff] & ~lane) | (wide & lane);
          `RES_MASK2: mask2_ff <= (mask2_ff & ~lane) | (wide & lane);
          default: begin
            MEM_WR <= 1'b1;
            MEM_ADDR <= wdst == `RES_MEM_MATCH ? MATCH_ADDR :
              wdst == `RES_MEM_FREE ? FREE_ADDR : aptr;
            MEM_WDATA <= wide;
            MEM_BITEN <= lane & ~wmask;
            MEM_VAL_WR <= wseg_ff == `LAST_SEG;
            MEM_VAL <= wsel_ff[bank_ff][2:0];
            if (wseg_ff == `LAST_SEG && wdst == `RES_MEM_PTR) addr_ff[bank_ff] <= anext;
          end
        endcase
        // compare after last key or mask segment
        if (wseg_ff == `LAST_SEG && wdst < `RES_MEM_PTR) begin
          SEARCH_GO <= 1'b1;
          SEARCH_VAL <= `VAL_VALID;
          SEARCH_MASK <= wmask;
        end
      end
      // data read from the persistent source
      if (DATA_RD) begin
        rseg_ff <= rseg_ff + 2'h1;
        case (rsrc)
          `RES_KEY: DOUT <= key_ff[{rseg_ff, 4'h0} +: 16];
          `RES_MASK1: DOUT <= mask1_ff[bank_ff][{rseg_ff, 4'h0} +: 16];
          `RES_MASK2: DOUT <= mask2_ff[{rseg_ff, 4'h0} +: 16];
          default: DOUT <= MEM_RDATA[{rseg_ff, 4'h0} +: 16];
        endcase
        if (rseg_ff == `LAST_SEG && rsrc == `RES_MEM_PTR) begin
          addr_ff[bank_ff] <= anext;
          MEM_ADDR <= anext;
        end
      end
    end
  end
endmodule

// ---- cam_instruction_decoder_bench.sv ----
// self-checking bench for the cam instruction decoder
`include "cam_defines.vh"
module cam_instruction_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, en = 1, cw = 0, cr = 0, dw = 0, dr = 0, mem_wr, val_wr, go, full_n;
  logic [15:0] din = 16'h0000, dout;
  logic [15:0] stat = 16'h1e3c;
  logic [11:0] mem_addr;
  logic [2:0] mem_val, sval;
  logic [63:0] wdata, biten, rdata, smask;
  int n_fail = 0, checks = 0;
  localparam logic [63:0] K = 64'h8123_4567_89ab_cdef;
  localparam logic [63:0] M = 64'h0000_ffff_0000_00f0;
  localparam logic [63:0] KM = K ^ M;
  always #4 clk = ~clk;
  cam_instruction_decoder cam_instruction_decoder_i (.REF_CLK(clk), .SRST(srst), .CLK_EN(en),
    .CMD_WR(cw), .CMD_RD(cr), .DATA_WR(dw), .DATA_RD(dr), .DIN(din), .DOUT(dout),
    .STATUS_IN(stat), .MATCH_ADDR(12'h010), .FREE_ADDR(12'h020), .MEM_WR(mem_wr),
    .MEM_ADDR(mem_addr), .MEM_WDATA(wdata), .MEM_BITEN(biten), .MEM_VAL_WR(val_wr),
    .MEM_VAL(mem_val), .MEM_RDATA(rdata), .SEARCH_GO(go), .SEARCH_VAL(sval),
    .SEARCH_MASK(smask), .CHAIN_FULL_N(full_n));
  cam_mem_model cam_mem_model_i (.clk(clk), .wr(mem_wr), .addr(mem_addr), .wdata(wdata),
    .biten(biten), .rdata(rdata));
  // one strobe (0 cmd wr, 1 cmd rd, 2 data wr, 3 data rd); look just after the taking edge
  task automatic pulse(input int k, input logic [15:0] d);
    @(posedge clk);
    {cw, cr, dw, dr} <= 4'b1000 >> k;
    din <= d;
    @(posedge clk);
    {cw, cr, dw, dr} <= 4'h0;
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a word is four data cycles, low segment first
  task automatic put(input logic [63:0] w, input logic go_end);
    for (int i = 0; i < 4; i++) begin
      pulse(2, w[16*i +: 16]);
      chk(go, go_end && i == 3);
    end
  endtask
  task automatic get(input logic [63:0] exp);
    logic [63:0] w;
    for (int i = 0; i < 4; i++) begin
      pulse(3, 16'h0000);
      w[16*i +: 16] = dout;
    end
    chk(w, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #40000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({full_n, go, mem_wr}, 3'b100);
    // target and source default to the search key
    put(K, 1);
    get(K);
    pulse(0, 16'h0108);
    put(M, 1);
    pulse(0, 16'h0140);
    put('1, 1);
    pulse(0, 16'h0000);
    get(K | ~M);
    // absolute memory target, written then read back by address
    pulse(0, 16'h0924);
    chk({mem_wr, go}, 2'b00);
    pulse(0, 16'h0123);
    put(K, 0);
    pulse(0, 16'h0804);
    pulse(0, 16'h0123);
    get(K);
    // masked move from memory into the key, then an idle
    pulse(0, 16'h0100);
    put(~K, 1);
    pulse(0, 16'h0b44);
    pulse(0, 16'h0123);
    pulse(0, 16'h0300);
    pulse(0, 16'h0000);
    get(KM);
    // validity write at a supplied address
    pulse(0, 16'h0c24);
    pulse(0, 16'h0045);
    chk({val_wr, mem_val, mem_addr}, {1'b1, 3'h4, 12'h045});
    // override: id, then status again, address load, refused selector write
    pulse(0, 16'h0218);
    pulse(1, 16'h0000);
    chk(dout[15:4], `DEVICE_ID);
    pulse(1, 16'h0000);
    chk(dout, stat);
    pulse(0, 16'h0230);
    pulse(0, 16'h0777);
    pulse(0, 16'h0230);
    pulse(1, 16'h0000);
    chk(dout, 16'h0777);
    pulse(0, 16'h0218);
    pulse(0, 16'h0002);
    get(KM);
    // forced search codes 4 to 7
    for (int v = 4; v < 8; v++) begin
      pulse(0, 16'h0500 | v[15:0]);
      chk({go, sval}, {1'b1, v[2:0]});
      if (v == 5) chk(smask, '1);
    end
    // key rotates right through the whole 64-bit field
    pulse(0, 16'h0603);
    pulse(0, 16'h0000);
    get({KM[0], KM[63:1]});
    // one read moves the source count; rewind brings it back to segment 0; sliding mask replicates its end bit
    pulse(3, 16'h0000);
    pulse(0, 16'h0602);
    get({KM[0], KM[63:1]});
    pulse(0, 16'h0110);
    put(64'h8000_0000_0000_00f1, 1);
    pulse(0, 16'h0613);
    pulse(0, 16'h0002);
    get(64'hc000_0000_0000_0078);
    pulse(0, 16'h0614);
    pulse(0, 16'h0002);
    get(64'h8000_0000_0000_00f0);
    // background set keeps its own first mask; foreground one is untouched
    pulse(0, 16'h0601);
    pulse(0, 16'h0108);
    put(64'h0f0f_0f0f_0f0f_0f0f, 1);
    pulse(0, 16'h0600);
    pulse(0, 16'h0001);
    get(M);
    // with the clock enable low the fill marker is not taken
    @(posedge clk);
    en <= 1'b0;
    pulse(0, 16'h0700);
    chk(full_n, 1);
    @(posedge clk);
    en <= 1'b1;
    // chain full output drops and stays down
    pulse(0, 16'h0700);
    chk(full_n, 0);
    pulse(0, 16'h0300);
    chk(full_n, 0);
    end_sim;
  end
endmodule

// ---- cam_mem_model.sv ----
// behavioural memory array on the far side of the decoder's memory port
module cam_mem_model (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [63:0] wdata,
  input wire logic [63:0] biten,
  // read side, combinational at the address
  output logic [63:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem_ff [0:4095];
  always @(posedge clk) begin
    if (wr) begin
      mem_ff[addr] <= (mem_ff[addr] & ~biten) | (wdata & biten);
    end
  end
  // unloaded entries read unknown, so a stray read shows up at once
  assign rdata = mem_ff[addr];
endmodule

// ---- cam_shifter.v ----
// shift unit for the search key and sliding mask
`include "cam_defines.vh"
module cam_shifter (
  // operands
  input wire [63:0] key_in,
  input wire [63:0] mask_in,
  input wire [1:0] width_sel,
  input wire left,
  // results
  output wire [63:0] key_out,
  output wire [63:0] mask_out
);
  // cam field top index: 64, 48, 32 or 16 bits
  wire [5:0] top = {width_sel, 4'hf} ^ 6'h30;
  genvar i;
  // each bit picks its neighbour; bits beyond the field stay put
  generate
    for (i = 0; i < `WORD_BITS; i = i + 1) begin : g_bit
      wire above = (i > top);
      wire is_top = (i == top);
      // neighbour indexes are elaboration constants, so no width is cut
      localparam integer up_i = (i == 63) ? 0 : i + 1;
      localparam integer dn_i = (i == 0) ? 0 : i - 1;
      // key rotates inside the field
      assign key_out[i] = above ? key_in[i] :
        left ? ((i == 0) ? key_in[top] : key_in[dn_i]) :
        (is_top ? key_in[0] : key_in[up_i]);
      // mask slides: end bit replicated, other end falls off
      assign mask_out[i] = above ? mask_in[i] :
        left ? ((i == 0) ? mask_in[0] : mask_in[dn_i]) :
        (is_top ? mask_in[top] : mask_in[up_i]);
    end
  endgenerate
endmodule
